// ### verilog/test_xor_and_extension_decoder.v
// decode and execute of test-skip, xor, extended pointer and move instructions
`timescale 1ns/1ns
`default_nettype none
`include "xdec_defs.vh"

// Behaviour
// - test-register-skip with a zero operand discards the next fetched instruction as a nop.
// - test-register-skip takes one cycle, two on a skip, three when the skipped word pair is two words.
// - access bit 0 selects the access bank, access bit 1 uses the bank select register.
// - with access bit 0 and extensions on, addresses up to 95 are indexed from pointer two.
// - xor-immediate xors the working register with the literal into the working register, updating N and Z.
// - xor-register writes to the working register when d is 0 and to the file register when d is 1.
// - xor-register completes in one cycle and changes only the N and Z flags.
// - extended instructions and indexed addressing work only while the extension enable bit is set, default set.
// - add-literal-pointer adds six bits to the chosen pointer; field 11 adds to pointer two and returns in two cycles.
// - subtract-literal-pointer subtracts six bits; field 11 subtracts from pointer two and returns in two cycles.
// - the fixed call opcode calls with the low target byte from the working register in two cycles, no flags.
// - move-stack-to-register takes a 7-bit offset from pointer two and a 12-bit destination, in two cycles.
// - move-stack-to-stack takes 7-bit source and destination offsets from pointer two, in two cycles.
// - push-literal stores the literal at pointer two then decrements pointer two, one cycle, no flags.
// - the working-register call pushes the next address and loads the counter from working register and latches.
// - the return variants load the counter from the top of the return stack, second cycle a nop.
module test_xor_and_extension_decoder #(
	parameter PC_W = 21,
	parameter ADDR_W = 12
) (
	input wire clk_sys,
	input wire srst,
	input wire [15:0] instr_word,
	input wire instr_valid,
	input wire extension_enable_bit,
	input wire [7:0] file_rdata,
	input wire [3:0] bank_select_register,
	input wire [PC_W-1:0] pc_next,
	input wire [PC_W-1:0] top_of_return_stack,
	input wire [7:0] counter_high_latch,
	input wire [4:0] counter_upper_latch,
	output reg [ADDR_W-1:0] file_addr_ff,
	output reg file_we_ff,
	output reg [7:0] file_wdata_ff,
	output reg [7:0] working_register_ff,
	output reg [7:0] status_ff,
	output reg [ADDR_W-1:0] ptr0_ff,
	output reg [ADDR_W-1:0] ptr1_ff,
	output reg [ADDR_W-1:0] pointer_two_ff,
	output reg pc_load_ff,
	output reg [PC_W-1:0] pc_target_ff,
	output reg stack_push_ff,
	output reg [PC_W-1:0] stack_push_data_ff,
	output reg stack_pop_ff,
	output reg flush_ff,
	output reg busy_ff
);

	//----------------------------------------
	// state and helpers
	//----------------------------------------
	localparam ST_EXEC = 4'b0001;
	localparam ST_NOP = 4'b0010;
	localparam ST_MOVE2 = 4'b0100;
	localparam ST_SKIP2 = 4'b1000;

	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [ADDR_W-1:0] move_src_ff;
	reg [ADDR_W-1:0] nxt_move_src;
	reg move_ss_ff;
	reg nxt_move_ss;
	reg [ADDR_W-1:0] nxt_file_addr;
	reg nxt_file_we;
	reg [7:0] nxt_file_wdata;
	reg [7:0] nxt_work;
	reg [7:0] nxt_status;
	reg [ADDR_W-1:0] nxt_ptr0;
	reg [ADDR_W-1:0] nxt_ptr1;
	reg [ADDR_W-1:0] nxt_ptr2;
	reg nxt_pc_load;
	reg [PC_W-1:0] nxt_pc_target;
	reg nxt_push;
	reg [PC_W-1:0] nxt_push_data;
	reg nxt_pop;
	reg nxt_flush;
	reg nxt_busy;
	reg [7:0] xor_res;
	reg [ADDR_W-1:0] ptr_sel;
	reg [ADDR_W-1:0] ptr_new;

	// effective data address of a byte-oriented operand
	function [ADDR_W-1:0] eff_addr;
		input [7:0] f;
		input a;
		input ext;
		input [3:0] bank;
		input [ADDR_W-1:0] p2;
		begin
			if (!a && ext && (f <= `ACCESS_INDEX_LIMIT))
				eff_addr = p2 + {{(ADDR_W-8){1'b0}}, f};
			else if (!a)
				eff_addr = {{(ADDR_W-8){f[7]}}, f};
			else
				eff_addr = {bank, f};
		end
	endfunction

	// status update for N and Z only, other bits kept
	function [7:0] nz_flags;
		input [7:0] old;
		input [7:0] res;
		reg [7:0] s;
		begin
			s = old;
			s[`FLAG_ZERO] = (res == 8'h00);
			s[`FLAG_NEG] = res[7];
			nz_flags = s;
		end
	endfunction

	// second-word detection for the three-cycle skip
	function is_two_word;
		input [15:0] w;
		begin
			is_two_word = (w[15:8] == `OP_EXT_MOVE);
		end
	endfunction

	//----------------------------------------
	// decode and execute
	//----------------------------------------
	// file reads are taken as combinational from file_addr_ff set last cycle
	always @* begin
		nxt_state = state_ff;
		nxt_move_src = move_src_ff;
		nxt_move_ss = move_ss_ff;
		nxt_file_addr = file_addr_ff;
		nxt_file_we = 1'b0;
		nxt_file_wdata = file_wdata_ff;
		nxt_work = working_register_ff;
		nxt_status = status_ff;
		nxt_ptr0 = ptr0_ff;
		nxt_ptr1 = ptr1_ff;
		nxt_ptr2 = pointer_two_ff;
		nxt_pc_load = 1'b0;
		nxt_pc_target = pc_target_ff;
		nxt_push = 1'b0;
		nxt_push_data = stack_push_data_ff;
		nxt_pop = 1'b0;
		nxt_flush = 1'b0;
		nxt_busy = 1'b0;
		xor_res = working_register_ff ^ file_rdata;
		ptr_sel = pointer_two_ff;
		ptr_new = pointer_two_ff;
		case (state_ff)
			ST_EXEC: begin
				if (instr_valid) begin
					if (instr_word[15:9] == `OP_TEST_SKIP) begin
						nxt_file_addr = eff_addr(instr_word[7:0], instr_word[8],
							extension_enable_bit, bank_select_register, pointer_two_ff);
						if (file_rdata == 8'h00) begin
							nxt_flush = 1'b1;
							nxt_busy = 1'b1;
							nxt_state = ST_SKIP2;
						end
					end else if (instr_word[15:8] == `OP_XOR_IMM) begin
						nxt_work = working_register_ff ^ instr_word[7:0];
						nxt_status = nz_flags(status_ff, working_register_ff ^ instr_word[7:0]);
					end else if (instr_word[15:10] == `OP_XOR_REG) begin
						nxt_file_addr = eff_addr(instr_word[7:0], instr_word[8],
							extension_enable_bit, bank_select_register, pointer_two_ff);
						nxt_status = nz_flags(status_ff, xor_res);
						if (instr_word[9]) begin
							nxt_file_we = 1'b1;
							nxt_file_wdata = xor_res;
						end else begin
							nxt_work = xor_res;
						end
					end else if (extension_enable_bit) begin
						if (instr_word == `OP_CALL_WORK) begin
							nxt_push = 1'b1;
							nxt_push_data = pc_next;
							nxt_pc_target = {counter_upper_latch, counter_high_latch,
								working_register_ff};
							nxt_pc_load = 1'b1;
							nxt_busy = 1'b1;
							nxt_state = ST_NOP;
						end else if ((instr_word[15:8] == `OP_EXT_ADD) ||
							(instr_word[15:8] == `OP_EXT_SUB)) begin
							case (instr_word[7:6])
								2'h0: ptr_sel = ptr0_ff;
								2'h1: ptr_sel = ptr1_ff;
								default: ptr_sel = pointer_two_ff;
							endcase
							if (instr_word[8])
								ptr_new = ptr_sel - {{(ADDR_W-6){1'b0}}, instr_word[5:0]};
							else
								ptr_new = ptr_sel + {{(ADDR_W-6){1'b0}}, instr_word[5:0]};
							case (instr_word[7:6])
								2'h0: nxt_ptr0 = ptr_new;
								2'h1: nxt_ptr1 = ptr_new;
								default: nxt_ptr2 = ptr_new;
							endcase
							if (instr_word[7:6] == `PTR_FIELD_TWO_RET) begin
								nxt_pop = 1'b1;
								nxt_pc_target = top_of_return_stack;
								nxt_pc_load = 1'b1;
								nxt_busy = 1'b1;
								nxt_state = ST_NOP;
							end
						end else if (instr_word[15:8] == `OP_EXT_PUSH) begin
							nxt_file_addr = pointer_two_ff;
							nxt_file_we = 1'b1;
							nxt_file_wdata = instr_word[7:0];
							nxt_ptr2 = pointer_two_ff - {{(ADDR_W-1){1'b0}}, 1'b1};
						end else if (instr_word[15:8] == `OP_EXT_MOVE) begin
							nxt_move_src = pointer_two_ff +
								{{(ADDR_W-7){1'b0}}, instr_word[6:0]};
							nxt_file_addr = nxt_move_src;
							nxt_move_ss = instr_word[7];
							nxt_busy = 1'b1;
							nxt_state = ST_MOVE2;
						end
					end
				end
			end
			ST_NOP: begin
				nxt_state = ST_EXEC; // second cycle of call or return, third cycle of a skip over a two-word instruction
			end
			ST_SKIP2: begin
				// the discarded word arrives now; a two-word one costs one more
				if (instr_valid && is_two_word(instr_word)) begin
					nxt_flush = 1'b1;
					nxt_busy = 1'b1;
					nxt_state = ST_NOP;
				end else begin
					nxt_state = ST_EXEC;
				end
			end
			ST_MOVE2: begin
				// source byte sits on the read port while the second word is decoded
				// a late second word only stretches busy; nothing is written early
				if (instr_valid && (instr_word[15:12] == `OP_SECOND_WORD)) begin
					nxt_file_we = 1'b1;
					nxt_file_wdata = file_rdata;
					if (move_ss_ff)
						nxt_file_addr = pointer_two_ff +
							{{(ADDR_W-7){1'b0}}, instr_word[6:0]};
					else
						nxt_file_addr = instr_word[ADDR_W-1:0];
					nxt_state = ST_EXEC;
				end else begin
					nxt_busy = 1'b1;
				end
			end
			default: nxt_state = ST_EXEC;
		endcase
	end

	//----------------------------------------
	// registers
	//----------------------------------------
	// single clock, synchronous reset; every output registered
	always @(posedge clk_sys) begin
		if (srst) begin
			state_ff <= ST_EXEC;
			move_src_ff <= {ADDR_W{1'b0}};
			move_ss_ff <= 1'b0;
			file_addr_ff <= {ADDR_W{1'b0}};
			file_we_ff <= 1'b0;
			file_wdata_ff <= 8'h00;
			working_register_ff <= 8'h00;
			status_ff <= 8'h00;
			ptr0_ff <= {ADDR_W{1'b0}};
			ptr1_ff <= {ADDR_W{1'b0}};
			pointer_two_ff <= {ADDR_W{1'b0}};
			pc_load_ff <= 1'b0;
			pc_target_ff <= {PC_W{1'b0}};
			stack_push_ff <= 1'b0;
			stack_push_data_ff <= {PC_W{1'b0}};
			stack_pop_ff <= 1'b0;
			flush_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			move_src_ff <= nxt_move_src;
			move_ss_ff <= nxt_move_ss;
			file_addr_ff <= nxt_file_addr;
			file_we_ff <= nxt_file_we;
			file_wdata_ff <= nxt_file_wdata;
			working_register_ff <= nxt_work;
			status_ff <= nxt_status;
			ptr0_ff <= nxt_ptr0;
			ptr1_ff <= nxt_ptr1;
			pointer_two_ff <= nxt_ptr2;
			pc_load_ff <= nxt_pc_load;
			pc_target_ff <= nxt_pc_target;
			stack_push_ff <= nxt_push;
			stack_push_data_ff <= nxt_push_data;
			stack_pop_ff <= nxt_pop;
			flush_ff <= nxt_flush;
			busy_ff <= nxt_busy;
		end
	end

endmodule // test_xor_and_extension_decoder
`default_nettype wire

// ### verilog/xdec_defs.vh
// opcode fields, flag positions and cycle counts for the test/xor/extension decoder
`ifndef XDEC_DEFS_VH
`define XDEC_DEFS_VH
`define OP_TEST_SKIP 7'h33
`define OP_XOR_IMM 8'h0A
`define OP_XOR_REG 6'h06
`define OP_EXT_ADD 8'hE8
`define OP_EXT_SUB 8'hE9
`define OP_EXT_PUSH 8'hEA
`define OP_EXT_MOVE 8'hEB
`define OP_SECOND_WORD 4'hF
`define OP_CALL_WORK 16'h0014
`define ACCESS_INDEX_LIMIT 8'h5F
`define PTR_FIELD_TWO_RET 2'h3
`define FLAG_ZERO 2
`define FLAG_NEG 4
`define EXT_ENABLE_RESET 1'b1
`define CYC_SKIP_ONE 2'h1
`define CYC_SKIP_TWO 2'h2
`endif

// ### test/file_model.sv
// file register read model for the decoder bench
`timescale 1ns/1ns
`default_nettype none
module file_model (
	input wire logic [15:0] instr_word,
	output logic [7:0] file_rdata
);
	// read data follows the decoded address byte; the pattern puts the only zero at A5h
	assign file_rdata = instr_word[7:0] ^ 8'hA5;
endmodule // file_model
`default_nettype wire

// ### test/xdec_assertions.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ns
`default_nettype none
module xdec_checker #(parameter PC_W = 21, parameter ADDR_W = 12) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	input wire logic extension_enable_bit,
	input wire logic [7:0] file_rdata,
	input wire logic [PC_W-1:0] pc_next,
	input wire logic [PC_W-1:0] top_of_return_stack,
	input wire logic [7:0] counter_high_latch,
	input wire logic [4:0] counter_upper_latch,
	input wire logic [ADDR_W-1:0] file_addr_ff,
	input wire logic file_we_ff,
	input wire logic [7:0] file_wdata_ff,
	input wire logic [7:0] working_register_ff,
	input wire logic [7:0] status_ff,
	input wire logic [ADDR_W-1:0] pointer_two_ff,
	input wire logic pc_load_ff,
	input wire logic [PC_W-1:0] pc_target_ff,
	input wire logic stack_push_ff,
	input wire logic [PC_W-1:0] stack_push_data_ff,
	input wire logic stack_pop_ff,
	input wire logic flush_ff,
	input wire logic busy_ff
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// a fresh word is taken only when the previous one left no second cycle
	wire logic go = instr_valid & ~busy_ff;
	wire logic ext = go & extension_enable_bit;
	a_xor_imm_value: assert property (
		go && instr_word[15:8] == 8'h0A |=> working_register_ff ==
		$past(working_register_ff ^ instr_word[7:0])) else $error("xor immediate value wrong");
	a_xor_imm_flags: assert property (
		go && instr_word[15:8] == 8'h0A |=> status_ff[2] == (working_register_ff == 8'h00)
		&& status_ff[4] == working_register_ff[7]) else $error("xor immediate flags wrong");
	a_skip_on_zero: assert property (
		go && instr_word[15:9] == 7'h33 && file_rdata == 8'h00 |=> flush_ff && busy_ff)
		else $error("zero test did not flush");
	a_no_skip_nonzero: assert property (
		go && instr_word[15:9] == 7'h33 && file_rdata != 8'h00 |=> !flush_ff && !busy_ff)
		else $error("nonzero test flushed");
	a_call_work_reg: assert property (
		ext && instr_word == 16'h0014 |=> stack_push_ff && pc_load_ff && stack_push_data_ff ==
		$past(pc_next) && pc_target_ff == {$past(counter_upper_latch),
		$past(counter_high_latch), $past(working_register_ff)}) else $error("call wrong");
	a_return_variant: assert property (
		ext && instr_word[15:9] == 7'h74 && instr_word[7:6] == 2'h3 |=> stack_pop_ff && pc_load_ff
		&& busy_ff && pc_target_ff == $past(top_of_return_stack) ##1 !pc_load_ff)
		else $error("return variant wrong");
	a_push_literal: assert property (
		ext && instr_word[15:8] == 8'hEA |=> file_we_ff && file_addr_ff == $past(pointer_two_ff)
		&& file_wdata_ff == $past(instr_word[7:0])
		&& pointer_two_ff == $past(pointer_two_ff) - 12'h001) else $error("push wrong");
	a_xor_reg_back: assert property (
		go && instr_word[15:9] == 7'h0D |=> file_we_ff && file_wdata_ff ==
		$past(working_register_ff ^ file_rdata)) else $error("xor register write wrong");
	a_ext_refused: assert property (
		go && !extension_enable_bit && instr_word[15:12] == 4'hE |=> !file_we_ff && !pc_load_ff
		&& $stable(pointer_two_ff)) else $error("extended opcode acted while disabled");
endmodule // xdec_checker
bind test_xor_and_extension_decoder xdec_checker #(.PC_W(PC_W), .ADDR_W(ADDR_W)) chk_u (
	.clk_sys(clk_sys), .srst(srst), .instr_word(instr_word), .instr_valid(instr_valid),
	.extension_enable_bit(extension_enable_bit), .file_rdata(file_rdata), .pc_next(pc_next),
	.top_of_return_stack(top_of_return_stack), .counter_high_latch(counter_high_latch),
	.counter_upper_latch(counter_upper_latch), .file_addr_ff(file_addr_ff),
	.file_we_ff(file_we_ff), .file_wdata_ff(file_wdata_ff), .status_ff(status_ff),
	.working_register_ff(working_register_ff), .pointer_two_ff(pointer_two_ff),
	.pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff), .stack_push_ff(stack_push_ff),
	.stack_push_data_ff(stack_push_data_ff), .stack_pop_ff(stack_pop_ff), .flush_ff(flush_ff),
	.busy_ff(busy_ff));
`default_nettype wire

// ### test/testbench.sv
// self-checking bench: instruction sequences with expected results
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [15:0] iw = 16'h0000;
	logic iv = 1'b0;
	logic en_ext = 1'b1;
	logic [3:0] bank = 4'h3;
	wire logic [7:0] rdata, wd, w, st;
	wire logic [11:0] addr, p0, p1, p2;
	wire logic we, ld, push, pop, flush, busy;
	wire logic [20:0] tgt, pdata;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	file_model fm_u (.instr_word(iw), .file_rdata(rdata));
	test_xor_and_extension_decoder dut_u (.clk_sys(clk_sys), .srst(srst), .instr_word(iw),
		.instr_valid(iv), .extension_enable_bit(en_ext), .file_rdata(rdata),
		.bank_select_register(bank), .pc_next(21'h012346), .top_of_return_stack(21'h0ABCDE),
		.counter_high_latch(8'hC3), .counter_upper_latch(5'h15), .file_addr_ff(addr),
		.file_we_ff(we), .file_wdata_ff(wd), .working_register_ff(w), .status_ff(st),
		.ptr0_ff(p0), .ptr1_ff(p1), .pointer_two_ff(p2), .pc_load_ff(ld), .pc_target_ff(tgt),
		.stack_push_ff(push), .stack_push_data_ff(pdata), .stack_pop_ff(pop),
		.flush_ff(flush), .busy_ff(busy));
	task tally_and_finish;
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// one word per edge; results are looked at 5 ns after the edge that takes it
	task issue(input logic [15:0] word);
		iw = word;
		iv = 1'b1;
		@(posedge clk_sys);
		#5;
	endtask
	initial forever #25 clk_sys = ~clk_sys;
	// hang guard: the whole sequence needs well under 100 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 500) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		#5 srst = 1'b0;
		`CHK(w, 8'h00)
		issue(16'h0A5A); `CHK(w, 8'h5A) `CHK(st, 8'h00)
		issue(16'h0A5A); `CHK(st, 8'h04)
		issue(16'h0A80); `CHK(st, 8'h10)
		issue(16'h1B22); `CHK(addr, 12'h322) `CHK(wd, 8'h07) `CHK(w, 8'h80)
		`CHK(st, 8'h00)
		issue(16'hEA7E); `CHK(addr, 12'h000) `CHK(wd, 8'h7E) `CHK(p2, 12'hFFF)
		issue(16'h1810); `CHK(addr, 12'h00F) `CHK(w, 8'h35) `CHK(we, 1'b0)
		issue(16'h1890); `CHK(addr, 12'hF90) `CHK(w, 8'h00)
		issue(16'hE80A); issue(16'hE84A); issue(16'hE943); issue(16'hE885);
		`CHK({p0, p1, p2}, 36'h00A007004)
		issue(16'hE8C5); `CHK(p2, 12'h009) `CHK(tgt, 21'h0ABCDE) `CHK(pop, 1'b1)
		issue(16'h0000); `CHK(ld, 1'b0)
		issue(16'hE9C1); `CHK(p2, 12'h008) `CHK(busy, 1'b1)
		issue(16'h0000);
		issue(16'h0A3C); issue(16'h0014); `CHK(tgt, 21'h15C33C) `CHK(pdata, 21'h012346)
		`CHK(st, 8'h00) `CHK({push, ld, busy}, 3'h7)
		issue(16'h0000);
		issue(16'h66A5); `CHK(flush, 1'b1)
		issue(16'hEB05); `CHK(flush, 1'b1)
		issue(16'hF123); `CHK(flush, 1'b0) `CHK(w, 8'h3C)
		issue(16'h6610); `CHK({flush, busy}, 2'h0)
		issue(16'hEB05); `CHK(addr, 12'h00D) `CHK(busy, 1'b1)
		issue(16'hF345); `CHK({we, addr, wd}, 21'h1345E0)
		issue(16'hEB85); `CHK(addr, 12'h00D)
		issue(16'hF007); `CHK({we, addr, wd}, 21'h100FA2)
		issue(16'h66A5); `CHK(flush, 1'b1)
		issue(16'h0A01); `CHK({flush, busy}, 2'h0) `CHK(w, 8'h3C)
		bank = 4'hA;
		issue(16'h1922); `CHK(addr, 12'hA22) `CHK(w, 8'hBB) `CHK(st, 8'h10)
		en_ext = 1'b0;
		issue(16'h1810); `CHK(addr, 12'h010) `CHK(w, 8'h0E)
		issue(16'hE80A); `CHK(p0, 12'h00A)
		issue(16'h0014); `CHK(ld, 1'b0)
		// mid-run reset clears the working state and the next word runs at once
		srst = 1'b1;
		iv = 1'b0;
		@(posedge clk_sys);
		#5;
		`CHK({w, st, p2, busy}, 29'h0000000)
		srst = 1'b0;
		issue(16'h0A11); `CHK(w, 8'h11) `CHK(st, 8'h00)
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
